// *** src/spc_ctrl.sv ***
// Operation control and time-slot selection for an HDLC serial port.
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"
module spc_ctrl
	import spc_pkg::*;
(
	input  wire logic      clock_i,              // 40 MHz system clock.
	input  wire logic      sys_rst_i,            // Synchronous reset.
	input  wire logic      ce_i,                 // Clock enable.
	// Host parallel bus.
	input  wire logic      cs_n_i,               // Chip select, active low.
	input  wire logic      rd_n_i,               // Read strobe, active low.
	input  wire logic      wr_n_i,               // Write strobe, active low.
	input  wire spc_addr_t addr_i,               // Register address.
	input  wire spc_byte_t wdata_i,              // Write data.
	output spc_byte_t      rdata_o,              // Read data.
	output logic           rdata_oe_n_o,         // Read data enable, low drives.
	// Controls held elsewhere in the device.
	input  wire logic      pin17_function_i,     // Pin 17 is slot strobe.
	input  wire logic      pin21_function_i,     // Pin 21 is receive data B.
	input  wire logic      tdm_highway_on_i,     // Highway mode on.
	input  wire logic      transparent_mode_i,   // No HDLC framing.
	// Serial highway.
	input  wire logic      tx_serial_clock_i,    // Transmit serial clock.
	input  wire logic      pin21_i,              // Receive clock or data B.
	input  wire logic      frame_sync_i,         // Frame sync.
	input  wire logic      rx_pin_a_i,           // Receive data A.
	output logic           tx_pin_a_o,           // Transmit data A.
	output logic           tx_pin_a_oe_n_o,      // Pin A enable, low drives.
	output logic           pin17_o,              // Data B or slot strobe.
	output logic           pin17_oe_n_o,         // Pin 17 enable, low drives.
	// HDLC engine side.
	input  wire logic      tx_bit_i,             // Next transmit bit.
	output logic           tx_bit_take_o,        // Transmit bit consumed.
	output logic           rx_bit_o,             // Received bit.
	output logic           rx_bit_valid_o,       // Received bit strobe.
	output logic           rx_reset_pulse_o,     // Receiver reset.
	output logic           tx_reset_pulse_o,     // Transmitter reset.
	output logic           tx_finished_set_o,    // Set done flag.
	output logic           tx_finished_clr_o,    // Clear done flag.
	output logic           regs_default_o,       // Restore all registers.
	output logic           low_power_o           // Data clock stopped.
);
	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	spc_byte_t op_ctrl;                // Operation control, reset bits zero.
	spc_byte_t tx_slot_control;        // Transmit slot and pin enables.
	spc_byte_t rx_slot_control;        // Receive slot, rate and pin select.
	logic      wr_seen_q;              // Write strobe seen last cycle.
	logic      rx_rst_q;               // Registered receiver reset pulse.
	logic      tx_rst_q;               // Registered transmitter reset pulse.
	logic      all_rst_q;              // Registered restore-defaults pulse.
	spc_byte_t next_op_ctrl;
	spc_byte_t next_tx_slot_control;
	spc_byte_t next_rx_slot_control;
	logic      next_wr_seen;
	logic      next_rx_rst;
	logic      next_tx_rst;
	logic      next_all_rst;
	logic      wr_take;                // One write taken this cycle.
	logic      rd_seen;                // Select and read both low.

	// A write is taken on the first cycle of the strobe, so a long
	// strobe cannot fire the reset pulses more than once.
	always_comb
	begin
		rd_seen              = ~cs_n_i & ~rd_n_i;
		next_wr_seen         = ~cs_n_i & ~wr_n_i;
		wr_take              = next_wr_seen & ~wr_seen_q;
		next_op_ctrl         = op_ctrl;
		next_tx_slot_control = tx_slot_control;
		next_rx_slot_control = rx_slot_control;
		next_rx_rst          = 1'b0;
		next_tx_rst          = 1'b0;
		next_all_rst         = 1'b0;
		if (rd_seen)
			next_op_ctrl[`SPC_OP_FLOAT] = 1'b0;
		if (wr_take)
		begin
			if (addr_i == `SPC_OFS_OP_CTRL)
			begin
				next_op_ctrl = wdata_i;
				next_op_ctrl[`SPC_OP_RX_RST] = 1'b0;
				next_op_ctrl[`SPC_OP_TX_RST] = 1'b0;
				next_rx_rst = wdata_i[`SPC_OP_RX_RST];
				next_tx_rst = wdata_i[`SPC_OP_TX_RST];
				if (wdata_i[`SPC_OP_RX_RST] & wdata_i[`SPC_OP_TX_RST])
				begin
					next_all_rst         = 1'b1;
					next_op_ctrl         = `SPC_RST_OP_CTRL;
					next_tx_slot_control = `SPC_RST_TX_SLOT;
					next_rx_slot_control = `SPC_RST_RX_SLOT;
				end
			end
			else if (addr_i == `SPC_OFS_TX_SLOT)
				next_tx_slot_control = wdata_i;
			else if (addr_i == `SPC_OFS_RX_SLOT)
				next_rx_slot_control = wdata_i;
		end
	end

	// Registers only; the clock enable freezes the whole bank.
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			op_ctrl         <= `SPC_RST_OP_CTRL;
			tx_slot_control <= `SPC_RST_TX_SLOT;
			rx_slot_control <= `SPC_RST_RX_SLOT;
			wr_seen_q       <= 1'b0;
			rx_rst_q        <= 1'b0;
			tx_rst_q        <= 1'b0;
			all_rst_q       <= 1'b0;
		end
		else if (ce_i)
		begin
			op_ctrl         <= next_op_ctrl;
			tx_slot_control <= next_tx_slot_control;
			rx_slot_control <= next_rx_slot_control;
			wr_seen_q       <= next_wr_seen;
			rx_rst_q        <= next_rx_rst;
			tx_rst_q        <= next_tx_rst;
			all_rst_q       <= next_all_rst;
		end
	end

	// ----------------------------------------------------------------
	// Decoded controls.
	// ----------------------------------------------------------------
	logic      floating;               // All outputs held off.
	logic      pin_b_data;             // Pin 17 carries data B.
	logic      rx_from_b;              // Receiver listens on pin 21.
	logic      rx_clk_level;           // Serial clock seen by the receiver.
	logic      tx_tick;                // Transmit bit tick.
	logic      rx_tick;                // Receive bit tick.
	logic      tx_in_slot;             // Transmit slot is current.
	logic      rx_in_slot;             // Receive slot is current.
	logic      rx_line_bit;            // Bit from the selected receive pin.

	always_comb
	begin
		floating     = op_ctrl[`SPC_OP_FLOAT];
		pin_b_data   = tx_slot_control[`SPC_TX_PIN_B_EN] & ~pin17_function_i;
		rx_from_b    = rx_slot_control[`SPC_RX_PIN_SEL];
		rx_clk_level = pin21_function_i ? tx_serial_clock_i : pin21_i;
		if (op_ctrl[`SPC_OP_LOOP_NEAR])
			rx_clk_level = tx_serial_clock_i;
		rx_line_bit  = rx_from_b ? pin21_i : rx_pin_a_i;
	end

	// ----------------------------------------------------------------
	// Bit ticks and slot position, one pair per direction.
	// ----------------------------------------------------------------
	// low power stops clock
	spc_clock_tick u_tx_tick (
		.clock_i      (clock_i),
		.sys_rst_i    (sys_rst_i),
		.ce_i         (ce_i),
		.serial_clk_i (tx_serial_clock_i),
		.half_rate_i  (rx_slot_control[`SPC_RX_HALF_RATE]),
		.stop_i       (op_ctrl[`SPC_OP_LOW_POWER]),
		.tick_o       (tx_tick)
	);

	spc_clock_tick u_rx_tick (
		.clock_i      (clock_i),
		.sys_rst_i    (sys_rst_i),
		.ce_i         (ce_i),
		.serial_clk_i (rx_clk_level),
		.half_rate_i  (rx_slot_control[`SPC_RX_HALF_RATE]),
		.stop_i       (op_ctrl[`SPC_OP_LOW_POWER]),
		.tick_o       (rx_tick)
	);

	spc_slot_tap u_tx_slot (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clear_i   (tx_rst_q),
		.tick_i    (tx_tick),
		.frame_i   (frame_sync_i),
		.slot_i    (tx_slot_control[`SPC_SLOT_MSB:`SPC_SLOT_LSB]),
		.in_slot_o (tx_in_slot)
	);

	spc_slot_tap u_rx_slot (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clear_i   (rx_rst_q),
		.tick_i    (rx_tick),
		.frame_i   (frame_sync_i),
		.slot_i    (rx_slot_control[`SPC_SLOT_MSB:`SPC_SLOT_LSB]),
		.in_slot_o (rx_in_slot)
	);

	// ----------------------------------------------------------------
	// Serial data path, all outputs from flip-flops except the bit take and the bus read enable.
	// ----------------------------------------------------------------
	logic      line_bit_q;             // Last bit from the receive pin.
	logic      tx_out_q;               // Bit on the transmit pins.
	logic      pin_a_on_q;             // Pin A driving.
	logic      pin_b_on_q;             // Pin 17 driving data B.
	logic      strobe_q;               // Slot strobe level on pin 17.
	logic      rx_bit_q;
	logic      rx_valid_q;
	spc_byte_t rdata_q;
	logic      next_line_bit;
	logic      next_tx_out;
	logic      next_pin_a_on;
	logic      next_pin_b_on;
	logic      next_strobe;
	logic      next_rx_bit;
	logic      next_rx_valid;
	spc_byte_t next_rdata;
	logic      tx_active;              // Transmitter enabled, slot current.
	logic      tx_stream;              // Bit headed for the pins.

	always_comb
	begin
		tx_active     = op_ctrl[`SPC_OP_TX_EN] & tx_in_slot;
		tx_stream     = op_ctrl[`SPC_OP_LOOP_FAR] ? line_bit_q : tx_bit_i;
		next_line_bit = rx_tick ? rx_line_bit : line_bit_q;
		next_tx_out   = tx_tick ? tx_stream : tx_out_q;
		tx_bit_take_o = tx_tick & tx_active & ~op_ctrl[`SPC_OP_LOOP_FAR];
		next_pin_a_on = tx_active & tx_slot_control[`SPC_TX_PIN_A_EN];
		next_pin_b_on = tx_active & pin_b_data;
		next_strobe   = tdm_highway_on_i & tx_in_slot;
		next_rx_bit   = rx_bit_q;
		next_rx_valid = 1'b0;
		if (rx_tick & rx_in_slot & op_ctrl[`SPC_OP_RX_EN] & ~rx_rst_q)
		begin
			next_rx_valid = 1'b1;
			next_rx_bit   = op_ctrl[`SPC_OP_LOOP_NEAR] ? tx_out_q : rx_line_bit;
		end
		// Reserved addresses read as zero.
		next_rdata = 8'h00;
		if (addr_i == `SPC_OFS_OP_CTRL)
			next_rdata = op_ctrl;
		else if (addr_i == `SPC_OFS_TX_SLOT)
			next_rdata = tx_slot_control;
		else if (addr_i == `SPC_OFS_RX_SLOT)
			next_rdata = rx_slot_control;
	end

	// Registers only.
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			line_bit_q <= 1'b1;
			tx_out_q   <= 1'b1;
			pin_a_on_q <= 1'b0;
			pin_b_on_q <= 1'b0;
			strobe_q   <= 1'b0;
			rx_bit_q   <= 1'b0;
			rx_valid_q <= 1'b0;
			rdata_q    <= 8'h00;
		end
		else if (ce_i)
		begin
			line_bit_q <= next_line_bit;
			tx_out_q   <= next_tx_out;
			pin_a_on_q <= next_pin_a_on;
			pin_b_on_q <= next_pin_b_on;
			strobe_q   <= next_strobe;
			rx_bit_q   <= next_rx_bit;
			rx_valid_q <= next_rx_valid;
			rdata_q    <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	// The bus enable is combinational so the byte appears while the
	// strobe is low; the data itself is registered one cycle earlier.
	always_comb
	begin
		rdata_o           = rdata_q;
		rdata_oe_n_o      = ~(rd_seen & ~floating);
		tx_pin_a_o        = tx_out_q;
		tx_pin_a_oe_n_o   = ~(pin_a_on_q & ~floating);
		pin17_o           = pin17_function_i ? strobe_q : tx_out_q;
		pin17_oe_n_o      = ~((pin17_function_i | pin_b_on_q) & ~floating);
		rx_bit_o          = rx_bit_q;
		rx_bit_valid_o    = rx_valid_q;
		rx_reset_pulse_o  = rx_rst_q;
		tx_reset_pulse_o  = tx_rst_q;
		tx_finished_set_o = tx_rst_q & transparent_mode_i;
		tx_finished_clr_o = tx_rst_q & ~transparent_mode_i;
		regs_default_o    = all_rst_q;
		low_power_o       = op_ctrl[`SPC_OP_LOW_POWER];
	end
endmodule : spc_ctrl
`default_nettype wire

// *** src/spc_params.svh ***
// Constants for the serial port operation and slot control block.
// Behaviour
// - Far-end loop returns received data outward
// - Near-end loop feeds transmit into receiver
// - Receiver takes data only while enabled
// - Transmitter sends on selected pins, else drains
// - Receiver reset bit gives one internal pulse
// - Transmitter reset pulses, clears underrun, sets empty
// - Transmit reset clears done (HDLC), sets (transparent)
// - Both reset bits restore defaults, no float
// - Float bit holds outputs off until read
// - Low-power bit stops the internal data clock
// - Six-bit transmit slot number, 0 to 63
// - Pin B data unless pin-17 function overrides
// - Pin A enable drives transmit data
// - Both pins carry same byte, same slot
// - Six-bit receive slot number, 0 to 63
// - Receive pin select: 0 pin A, 1 pin B
// - Pin-21 function: data B, clocked by transmit clock
// - Pin-17 function: slot strobe, data only on A
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets on the host bus.
// ----------------------------------------------------------------
`define SPC_OFS_OP_CTRL   5'h06
`define SPC_OFS_TX_SLOT   5'h07
`define SPC_OFS_RX_SLOT   5'h08

// ----------------------------------------------------------------
// Operation control field positions.
// ----------------------------------------------------------------
`define SPC_OP_LOOP_FAR   0
`define SPC_OP_LOOP_NEAR  1
`define SPC_OP_RX_EN      2
`define SPC_OP_TX_EN      3
`define SPC_OP_RX_RST     4
`define SPC_OP_TX_RST     5
`define SPC_OP_FLOAT      6
`define SPC_OP_LOW_POWER  7

// ----------------------------------------------------------------
// Slot control field positions.
// ----------------------------------------------------------------
`define SPC_SLOT_LSB      0
`define SPC_SLOT_MSB      5
`define SPC_TX_PIN_B_EN   6
`define SPC_TX_PIN_A_EN   7
`define SPC_RX_HALF_RATE  6
`define SPC_RX_PIN_SEL    7

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define SPC_RST_OP_CTRL   8'h00
`define SPC_RST_TX_SLOT   8'h00
`define SPC_RST_RX_SLOT   8'h00

`endif

// *** src/spc_pkg.sv ***
// Types shared by the serial port operation and slot control files.
package spc_pkg;
	typedef logic [7:0] spc_byte_t;   // One register or data byte.
	typedef logic [4:0] spc_addr_t;   // Host register address.
	typedef logic [5:0] spc_slot_t;   // Time slot number.
endpackage : spc_pkg

// *** src/spc_clock_tick.sv ***
// Edge detector turning a sampled serial clock into one-cycle ticks.
`timescale 1ns/1ps
`default_nettype none
module spc_clock_tick
	import spc_pkg::*;
(
	input  wire logic clock_i,       // System clock.
	input  wire logic sys_rst_i,     // Synchronous reset, active high.
	input  wire logic ce_i,          // Clock enable.
	input  wire logic serial_clk_i,  // Serial clock level, synchronous input.
	input  wire logic half_rate_i,   // Pass only every second edge.
	input  wire logic stop_i,        // Low-power stop of the data clock.
	output logic      tick_o         // One-cycle pulse per usable edge.
);
	// ----------------------------------------------------------------
	// Edge detection and divide-by-two.
	// ----------------------------------------------------------------
	logic prev_q;       // Serial clock one cycle ago.
	logic phase_q;      // Toggles on each rising edge for half rate.
	logic next_prev;
	logic next_phase;
	logic rise;         // Rising edge seen this cycle.

	// The edge is gated by the stop level so no tick leaves in low power.
	always_comb
	begin
		rise       = serial_clk_i & ~prev_q & ~stop_i;
		next_prev  = serial_clk_i;
		next_phase = rise ? ~phase_q : phase_q;
		tick_o     = rise & (~half_rate_i | phase_q);
	end

	// Registers only; the clock enable freezes both.
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			prev_q  <= 1'b0;
			phase_q <= 1'b0;
		end
		else if (ce_i)
		begin
			prev_q  <= next_prev;
			phase_q <= next_phase;
		end
	end
endmodule : spc_clock_tick
`default_nettype wire

// *** src/spc_slot_tap.sv ***
// Bit and slot counter that flags the selected time slot of a frame.
`timescale 1ns/1ps
`default_nettype none
module spc_slot_tap
	import spc_pkg::*;
(
	input  wire logic      clock_i,     // System clock.
	input  wire logic      sys_rst_i,   // Synchronous reset, active high.
	input  wire logic      ce_i,        // Clock enable.
	input  wire logic      clear_i,     // Side reset pulse.
	input  wire logic      tick_i,      // One pulse per serial bit.
	input  wire logic      frame_i,     // Frame sync level.
	input  wire spc_slot_t slot_i,      // Selected slot number.
	output logic           in_slot_o    // Current bit lies in the slot.
);
	// ----------------------------------------------------------------
	// Position counter: slot in the upper bits, bit in the lower three.
	// ----------------------------------------------------------------
	logic [8:0] pos_q;      // Bit position since frame sync.
	logic [8:0] next_pos;

	// Frame sync seen on a tick restarts the count at bit zero.
	always_comb
	begin
		next_pos = pos_q;
		if (clear_i)
			next_pos = 9'h000;
		else if (tick_i)
			next_pos = frame_i ? 9'h000 : 9'(pos_q + 9'h001);
		in_slot_o = (pos_q[8:3] == slot_i);
	end

	// Registers only.
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			pos_q <= 9'h000;
		else if (ce_i)
			pos_q <= next_pos;
	end
endmodule : spc_slot_tap
`default_nettype wire

// *** verification/spc_ctrl_sva.sv ***
// Concurrent checks on the ports of the operation and slot control block.
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"
module spc_ctrl_chk
	import spc_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      sys_rst_i,
	input  wire logic      cs_n_i,
	input  wire logic      rd_n_i,
	input  wire logic      wr_n_i,
	input  wire spc_addr_t addr_i,
	input  wire spc_byte_t wdata_i,
	input  wire logic      pin17_function_i,
	input  wire logic      tdm_highway_on_i,
	input  wire logic      transparent_mode_i,
	input  wire logic      tx_bit_i,
	input  wire logic      tx_pin_a_o,
	input  wire logic      tx_pin_a_oe_n_o,
	input  wire logic      pin17_o,
	input  wire logic      pin17_oe_n_o,
	input  wire logic      tx_bit_take_o,
	input  wire logic      rx_bit_valid_o,
	input  wire logic      rx_reset_pulse_o,
	input  wire logic      tx_reset_pulse_o,
	input  wire logic      tx_finished_set_o,
	input  wire logic      tx_finished_clr_o,
	input  wire logic      regs_default_o,
	input  wire logic      low_power_o
);
	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// A strobed access to the operation control register.
	wire op_wr = !cs_n_i && !wr_n_i && addr_i == `SPC_OFS_OP_CTRL;

	chk_rx_pulse_src:
	assert property (rx_reset_pulse_o |-> $past(op_wr && wdata_i[`SPC_OP_RX_RST]))
		else $error("receiver reset pulse without a write");
	chk_rx_pulse_one:
	assert property (rx_reset_pulse_o |=> !rx_reset_pulse_o)
		else $error("receiver reset pulse longer than one cycle");
	chk_tx_pulse_one:
	assert property (tx_reset_pulse_o |-> $past(op_wr && wdata_i[`SPC_OP_TX_RST]) ##1 !tx_reset_pulse_o)
		else $error("transmitter reset pulse wrong");
	chk_done_set:
	assert property (tx_finished_set_o == (tx_reset_pulse_o && transparent_mode_i))
		else $error("done flag set pulse wrong");
	chk_done_clear:
	assert property (tx_finished_clr_o == (tx_reset_pulse_o && !transparent_mode_i))
		else $error("done flag clear pulse wrong");
	chk_both_default:
	assert property (regs_default_o |-> rx_reset_pulse_o && tx_reset_pulse_o
		&& $past(op_wr && wdata_i[`SPC_OP_RX_RST] && wdata_i[`SPC_OP_TX_RST]))
		else $error("register default pulse wrong");
	chk_float_set:
	assert property (op_wr && $past(wr_n_i) && rd_n_i && wdata_i[`SPC_OP_FLOAT]
		&& !(wdata_i[`SPC_OP_RX_RST] && wdata_i[`SPC_OP_TX_RST])
		|=> ##1 tx_pin_a_oe_n_o && pin17_oe_n_o)
		else $error("outputs still driven after float write");
	chk_power_idle:
	assert property (low_power_o [*4] |-> !tx_bit_take_o && !rx_bit_valid_o)
		else $error("bit activity in low power");
	chk_pin_a_data:
	assert property (tx_bit_take_o |=> tx_pin_a_oe_n_o || tx_pin_a_o == $past(tx_bit_i))
		else $error("pin A data not the consumed bit");
	chk_same_both:
	assert property (!tx_pin_a_oe_n_o && !pin17_oe_n_o && !pin17_function_i
		|-> tx_pin_a_o == pin17_o)
		else $error("pins A and B differ");
	chk_strobe_low:
	assert property ((pin17_function_i && !tdm_highway_on_i) [*3] |-> !pin17_o)
		else $error("slot strobe high with highway off");

	// Main scenarios reached.
	cov_default: cover property (regs_default_o);
	cov_send: cover property (tx_bit_take_o && !tx_pin_a_oe_n_o);
	cov_receive: cover property (rx_bit_valid_o);
endmodule : spc_ctrl_chk

bind spc_ctrl spc_ctrl_chk i_chk (.clock_i, .sys_rst_i, .cs_n_i, .rd_n_i, .wr_n_i, .addr_i,
	.wdata_i, .pin17_function_i, .tdm_highway_on_i, .transparent_mode_i, .tx_bit_i,
	.tx_pin_a_o, .tx_pin_a_oe_n_o, .pin17_o, .pin17_oe_n_o, .tx_bit_take_o, .rx_bit_valid_o,
	.rx_reset_pulse_o, .tx_reset_pulse_o, .tx_finished_set_o, .tx_finished_clr_o,
	.regs_default_o, .low_power_o);
`default_nettype wire

// *** verification/spc_hwy_model.sv ***
// Behavioural model of the TDM serial highway at the far side.
`timescale 1ns/1ps
`default_nettype none
module spc_hwy_model
(
	input  wire logic clock_i,        // System clock.
	input  wire logic sys_rst_i,      // Restarts the frame.
	input  wire logic pin21_data_i,   // Pin 21 carries data, not a clock.
	input  wire logic a_level_i,      // Level sent on line A.
	input  wire logic b_level_i,      // Level sent on line B.
	output logic      serial_clock_o, // Bit clock, four system cycles a bit.
	output logic      frame_sync_o,   // Frame marker, two bits wide.
	output logic      rx_pin_a_o,     // Line A data.
	output logic      pin21_o         // Receive clock or line B data.
);
	logic [10:0] phase;      // Bit of frame in [10:2], cycle of bit in [1:0].
	logic [10:0] next_phase; // Next position; 512 bits make a frame.
	always_comb next_phase = sys_rst_i ? 11'h000 : phase + 11'h001;
	always_ff @(posedge clock_i) phase <= next_phase;
	assign serial_clock_o = phase[1];
	// Two bits wide so that half-rate sampling still sees it.
	assign frame_sync_o = (phase[10:3] == 8'hff);
	assign rx_pin_a_o = a_level_i;
	assign pin21_o = pin21_data_i ? b_level_i : phase[1];
endmodule : spc_hwy_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the operation and slot control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import spc_pkg::*;
;
	logic      clock_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
	logic      cs_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1;
	spc_addr_t addr_i = 5'h00;
	spc_byte_t wdata_i = 8'h00, rdata_o;
	logic      pin17_function_i = 1'b0, pin21_function_i = 1'b0, tdm_highway_on_i = 1'b0;
	logic      transparent_mode_i = 1'b0, tx_bit_i = 1'b0, a_lvl = 1'b0, b_lvl = 1'b0;
	wire logic tx_serial_clock_i, pin21_i, frame_sync_i, rx_pin_a_i;
	logic      rdata_oe_n_o, tx_pin_a_o, tx_pin_a_oe_n_o, pin17_o, pin17_oe_n_o;
	logic      tx_bit_take_o, rx_bit_o, rx_bit_valid_o, rx_reset_pulse_o, tx_reset_pulse_o;
	logic      tx_finished_set_o, tx_finished_clr_o, regs_default_o, low_power_o;
	int        fail_count = 0, total_checks = 0;
	int        p_rx = 0, p_tx = 0, p_set = 0, p_clr = 0, p_def = 0; // Pulse totals.

	spc_ctrl i_dut (.clock_i, .sys_rst_i, .ce_i, .cs_n_i, .rd_n_i, .wr_n_i, .addr_i, .wdata_i,
		.rdata_o, .rdata_oe_n_o, .pin17_function_i, .pin21_function_i, .tdm_highway_on_i,
		.transparent_mode_i, .tx_serial_clock_i, .pin21_i, .frame_sync_i, .rx_pin_a_i,
		.tx_pin_a_o, .tx_pin_a_oe_n_o, .pin17_o, .pin17_oe_n_o, .tx_bit_i, .tx_bit_take_o,
		.rx_bit_o, .rx_bit_valid_o, .rx_reset_pulse_o, .tx_reset_pulse_o, .tx_finished_set_o,
		.tx_finished_clr_o, .regs_default_o, .low_power_o);
	spc_hwy_model i_hwy (.clock_i, .sys_rst_i, .pin21_data_i(pin21_function_i), .a_level_i(a_lvl),
		.b_level_i(b_lvl), .serial_clock_o(tx_serial_clock_i), .frame_sync_o(frame_sync_i),
		.rx_pin_a_o(rx_pin_a_i), .pin21_o(pin21_i));

	// ----------------------------------------------------------------
	// Clock, pulse counting and watchdog.
	// ----------------------------------------------------------------
	initial forever #12.5 clock_i = ~clock_i;
	// Pulses are counted at the settled falling edge.
	always @(negedge clock_i)
	begin
		if (!sys_rst_i)
		begin
			p_rx += rx_reset_pulse_o;
			p_tx += tx_reset_pulse_o;
			p_set += tx_finished_set_o;
			p_clr += tx_finished_clr_o;
			p_def += regs_default_o;
		end
	end
	// More than twice the planned run.
	initial
	begin
		#2500000;
		fail_count++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Shared tasks, entered just after a falling edge.
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input spc_addr_t a, input spc_byte_t d);
		addr_i = a;
		wdata_i = d;
		cs_n_i = 1'b0;
		wr_n_i = 1'b0;
		@(negedge clock_i);
		cs_n_i = 1'b1;
		wr_n_i = 1'b1;
		@(negedge clock_i);
	endtask : wr
	task automatic rd(input spc_addr_t a, input spc_byte_t exp);
		addr_i = a;
		cs_n_i = 1'b0;
		rd_n_i = 1'b0;
		@(negedge clock_i);
		chk({rdata_oe_n_o, rdata_o}, {1'b0, exp});
		cs_n_i = 1'b1;
		rd_n_i = 1'b1;
		@(negedge clock_i);
	endtask : rd
	// Counts one frame; negative expectations are skipped.
	task automatic frame(input int e_take, e_val, e_one, e_oea, e_oeb, e_hia, e_p17, e_gap);
		int e[8] = '{e_take, e_val, e_one, e_oea, e_oeb, e_hia, e_p17, e_gap};
		int c[8] = '{0, 0, 0, 0, 0, 0, 0, 9999};
		int g = -100000;
		int w = 0;
		while (frame_sync_i !== 1'b1 && w < 3000)
		begin
			@(negedge clock_i);
			w++;
		end
		chk(w < 3000, 1);
		repeat (2048)
		begin
			@(negedge clock_i);
			c[0] += tx_bit_take_o;
			c[1] += rx_bit_valid_o;
			c[2] += rx_bit_valid_o & rx_bit_o;
			c[3] += !tx_pin_a_oe_n_o;
			c[4] += !pin17_oe_n_o;
			c[5] += !tx_pin_a_oe_n_o & tx_pin_a_o;
			c[6] += pin17_o;
			if (tx_bit_take_o)
			begin
				if (g > 0 && g < c[7])
					c[7] = g;
				g = 0;
			end
			g++;
		end
		foreach (e[i])
			if (e[i] >= 0)
				chk(c[i], e[i]);
	endtask : frame

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_regs;
		rd(5'h06, 8'h00);
		rd(5'h07, 8'h00);
		rd(5'h08, 8'h00);
		wr(5'h07, 8'hff);
		ce_i = 1'b0;
		wr(5'h07, 8'h11);
		ce_i = 1'b1;
		rd(5'h07, 8'hff);
		wr(5'h08, 8'haa);
		rd(5'h08, 8'haa);
		wr(5'h1f, 8'h55);
		rd(5'h1f, 8'h00);
		wr(5'h06, 8'h0d);
		rd(5'h06, 8'h0d);
		$display("test regs done");
	endtask : t_regs
	task automatic t_resets;
		wr(5'h06, 8'h14);
		rd(5'h06, 8'h04);
		chk(p_rx, 1);
		chk(p_tx, 0);
		wr(5'h06, 8'h20);
		chk(p_tx, 1);
		chk(p_clr, 1);
		transparent_mode_i = 1'b1;
		wr(5'h06, 8'h20);
		chk(p_set, 1);
		chk(p_clr, 1);
		wr(5'h06, 8'h3c);
		chk(p_def, 1);
		rd(5'h06, 8'h00);
		rd(5'h07, 8'h00);
		rd(5'h08, 8'h00);
		$display("test resets done");
	endtask : t_resets
	task automatic t_tx;
		wr(5'h07, 8'h8a);
		wr(5'h06, 8'h08);
		frame(8, -1, -1, 32, 0, 0, -1, 4);
		wr(5'h07, 8'hed);
		frame(8, -1, -1, 32, 32, 0, -1, 4);
		pin17_function_i = 1'b1;
		frame(8, -1, -1, 32, -1, -1, 0, -1);
		tdm_highway_on_i = 1'b1;
		frame(8, -1, -1, 32, -1, -1, 32, -1);
		wr(5'h07, 8'h4a);
		frame(8, -1, -1, 0, -1, -1, -1, -1);
		pin17_function_i = 1'b0;
		tdm_highway_on_i = 1'b0;
		wr(5'h07, 8'h0a);
		frame(8, -1, -1, 0, 0, -1, -1, -1);
		wr(5'h06, 8'h00);
		frame(0, -1, -1, 0, 0, -1, -1, -1);
		wr(5'h07, 8'h8a);
		tx_bit_i = 1'b1;
		wr(5'h06, 8'h09);
		frame(0, -1, -1, -1, -1, 0, -1, -1);
		wr(5'h06, 8'h88);
		chk(low_power_o, 1'b1);
		frame(0, -1, -1, -1, -1, -1, -1, -1);
		wr(5'h06, 8'h08);
		wr(5'h08, 8'h40);
		frame(8, -1, -1, 64, -1, -1, -1, 8);
		wr(5'h08, 8'h00);
		wr(5'h06, 8'h48);
		frame(-1, -1, -1, 0, 0, -1, -1, -1);
		rd(5'h07, 8'h8a);
		frame(8, -1, -1, 32, -1, -1, -1, -1);
		$display("test transmit done");
	endtask : t_tx
	task automatic t_rx;
		a_lvl = 1'b1;
		wr(5'h06, 8'h00);
		wr(5'h08, 8'h14);
		wr(5'h06, 8'h04);
		frame(-1, 8, 8, -1, -1, -1, -1, -1);
		wr(5'h06, 8'h00);
		frame(-1, 0, 0, -1, -1, -1, -1, -1);
		pin21_function_i = 1'b1;
		wr(5'h08, 8'h94);
		wr(5'h06, 8'h04);
		frame(-1, 8, 0, -1, -1, -1, -1, -1);
		pin21_function_i = 1'b0;
		a_lvl = 1'b0;
		wr(5'h08, 8'h14);
		wr(5'h07, 8'h94);
		wr(5'h06, 8'h0e);
		frame(-1, 8, 8, -1, -1, -1, -1, -1);
		$display("test receive done");
	endtask : t_rx

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// Twelve cycles of reset, then the scenarios.
	initial
	begin
		repeat (12) @(posedge clock_i);
		@(negedge clock_i);
		sys_rst_i = 1'b0;
		@(negedge clock_i);
		t_regs();
		t_resets();
		t_tx();
		t_rx();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
